// File: hdl/mpg_top.v
// Purpose: general-purpose I/O for the second to fifth ports on APB
// Assumes: pclk 20 MHz; presetn asynchronous active low
// Notes:   pins split into in, out and output enable
// Function
// - direction bit 1 drives the pin; 0 leaves it a high-impedance input
// - reset clears every direction register, all pins inputs
// - data read returns latch where direction is 1, pin level otherwise
// - data writes always update the latch, whatever the direction
// - data latches keep their contents through reset
// - third port six bits wide; fourth and fifth ports eight bits
// - clock output enable drives half of pclk on third port pin 2
// - clock output overrides pin 2 direction; enable read/write, reset clear
// - ADC-selected fourth port pin (pins 0 to 6; pin 7 is masked off) reads 0 if input, else latch
// - timer pins ignore direction for drive; direction picks latch or 0
// - prescaler may pick pin 6 or 4 as timer clocks; direction ignored
// - fifth port eight bits; shared pins follow peripheral when owned
// - ADC-owned second port pins ignore direction; read latch or 0
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mpg_defs.vh"

module mpg_top (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire [31:0] prdata,
  output wire        pslverr,
  // peripheral selects
  input  wire [4:0]  analog_channel_select,
  input  wire [2:0]  timer_one_prescaler_select,
  input  wire [2:0]  timer_two_prescaler_select,
  input  wire [7:0]  fifth_port_periph_en,
  input  wire [7:0]  fifth_port_periph_out,
  input  wire [7:0]  fifth_port_periph_oe,
  // second port pins
  input  wire [7:0]  port_b_pin_in,
  output wire [7:0]  port_b_pin_out,
  output wire [7:0]  port_b_pin_oe,
  // third port pins
  input  wire [5:0]  port_c_pin_in,
  output wire [5:0]  port_c_pin_out,
  output wire [5:0]  port_c_pin_oe,
  // fourth port pins
  input  wire [7:0]  port_d_pin_in,
  output wire [7:0]  port_d_pin_out,
  output wire [7:0]  port_d_pin_oe,
  // fifth port pins
  input  wire [7:0]  port_e_pin_in,
  output wire [7:0]  port_e_pin_out,
  output wire [7:0]  port_e_pin_oe
);

  // ==========================================================
  // decode helpers
  // channels outside the port give an empty mask
  function [7:0] chan_mask;
    input [4:0] sel;
    input [4:0] base;
    reg   [4:0] off;
    begin
      off       = sel - base;
      chan_mask = 8'h00;
      if (sel >= base && off < 5'd8) begin
        chan_mask[off[2:0]] = 1'b1;
      end
    end
  endfunction

  // external clock code; same decode for both timers
  function ext_clk_sel;
    input [2:0] ps;
    begin
      ext_clk_sel = (ps == `MPG_PS_EXT);
    end
  endfunction

  // ==========================================================
  // address decode
  wire [5:0] idx     = paddr[7:2];
  wire       aligned = (paddr[1:0] == 2'b00);
  reg        hit;
  reg  [7:0] sel_reg;

  always @* begin
    hit     = aligned;
    sel_reg = 8'h00;
    if (idx == `MPG_IDX_B_LATCH) begin
      sel_reg[0] = 1'b1;
    end else if (idx == `MPG_IDX_C_LATCH) begin
      sel_reg[1] = 1'b1;
    end else if (idx == `MPG_IDX_D_LATCH) begin
      sel_reg[2] = 1'b1;
    end else if (idx == `MPG_IDX_B_DIR) begin
      sel_reg[3] = 1'b1;
    end else if (idx == `MPG_IDX_C_DIR) begin
      sel_reg[4] = 1'b1;
    end else if (idx == `MPG_IDX_D_DIR) begin
      sel_reg[5] = 1'b1;
    end else if (idx == `MPG_IDX_E_LATCH) begin
      sel_reg[6] = 1'b1;
    end else if (idx == `MPG_IDX_E_DIR) begin
      sel_reg[7] = 1'b1;
    end else begin
      hit = 1'b0;
    end
    if (!aligned) begin
      sel_reg = 8'h00;
    end
  end

  wire       wr_stb;
  wire [7:0] wr = sel_reg & {8{wr_stb}};

  // ==========================================================
  // clock output on third port
  reg clken_q;
  reg clk_tog_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clken_q <= 1'b0;
    end else if (wr[4]) begin
      clken_q <= pwdata[`MPG_CLKEN_BIT];
    end
  end

  // flop-born clock, half of pclk; keeps outputs registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_tog_q <= 1'b0;
    end else if (clken_q) begin
      clk_tog_q <= ~clk_tog_q;
    end else begin
      clk_tog_q <= 1'b0;
    end
  end

  // ==========================================================
  // sharing masks
  // ADC owns second port pins
  wire [7:0] adc_b = chan_mask(analog_channel_select, `MPG_ADC_B_BASE);
  wire [7:0] adc_d = chan_mask(analog_channel_select, `MPG_ADC_D_BASE) & 8'h7F;
  wire       ta_ext = ext_clk_sel(timer_one_prescaler_select);
  wire       tb_ext = ext_clk_sel(timer_two_prescaler_select);
  reg  [7:0] tim_d;
  always @* begin
    tim_d                 = 8'h00;
    tim_d[`MPG_TIMER_ONE_EXTERNAL_CLOCK_PIN] = ta_ext;
    tim_d[`MPG_TIMER_TWO_EXTERNAL_CLOCK_PIN] = tb_ext;
  end
  // timer pins: input, read latch or 0
  wire [7:0] own_d = adc_d | tim_d;

  wire [5:0] own_c = {3'b000, clken_q, 2'b00};
  // pin 2 carries the divided clock, other bits unused
  wire [5:0] clk_c_out = {3'b000, clk_tog_q, 2'b00};

  // ==========================================================
  // ports
  // latch copies stay inside each port; only readback leaves
  wire [7:0] b_dir;
  wire [7:0] b_rd;
  wire [5:0] c_dir;
  wire [5:0] c_rd;
  wire [7:0] d_dir;
  wire [7:0] d_rd;
  wire [7:0] e_dir;
  wire [7:0] e_rd;

  mpg_port #(.W(8)) u_port_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_latch   (wr[0]),
    .wr_dir     (wr[3]),
    .wdata      (pwdata[7:0]),
    .own        (adc_b),
    .own_out    (8'h00),
    .own_oe     (8'h00),
    .zero_if_in (adc_b),
    .rd_zero    (8'h00),
    .pin_in     (port_b_pin_in),
    .pin_out_q  (port_b_pin_out),
    .pin_oe_q   (port_b_pin_oe),
    .latch_q    (),
    .dir_q      (b_dir),
    .rdata      (b_rd)
  );

  mpg_port #(.W(6)) u_port_c (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_latch   (wr[1]),
    .wr_dir     (wr[4]),
    .wdata      (pwdata[5:0]),
    .own        (own_c),
    .own_out    (clk_c_out),
    .own_oe     (own_c),
    .zero_if_in (6'h00),
    .rd_zero    (own_c),
    .pin_in     (port_c_pin_in),
    .pin_out_q  (port_c_pin_out),
    .pin_oe_q   (port_c_pin_oe),
    .latch_q    (),
    .dir_q      (c_dir),
    .rdata      (c_rd)
  );

  mpg_port #(.W(8)) u_port_d (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_latch   (wr[2]),
    .wr_dir     (wr[5]),
    .wdata      (pwdata[7:0]),
    .own        (own_d),
    .own_out    (8'h00),
    .own_oe     (8'h00),
    .zero_if_in (own_d),
    .rd_zero    (8'h00),
    .pin_in     (port_d_pin_in),
    .pin_out_q  (port_d_pin_out),
    .pin_oe_q   (port_d_pin_oe),
    .latch_q    (),
    .dir_q      (d_dir),
    .rdata      (d_rd)
  );

  // shared pins follow peripheral; input reads pin
  mpg_port #(.W(8)) u_port_e (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_latch   (wr[6]),
    .wr_dir     (wr[7]),
    .wdata      (pwdata[7:0]),
    .own        (fifth_port_periph_en),
    .own_out    (fifth_port_periph_out),
    .own_oe     (fifth_port_periph_oe),
    .zero_if_in (8'h00),
    .rd_zero    (8'h00),
    .pin_in     (port_e_pin_in),
    .pin_out_q  (port_e_pin_out),
    .pin_oe_q   (port_e_pin_oe),
    .latch_q    (),
    .dir_q      (e_dir),
    .rdata      (e_rd)
  );

  // ==========================================================
  // read mux; reserved bits read zero
  reg [31:0] rd_value;
  always @* begin
    rd_value = 32'h0000_0000;
    if (sel_reg[0]) begin
      rd_value[7:0] = b_rd;
    end else if (sel_reg[1]) begin
      rd_value[5:0] = c_rd;
    end else if (sel_reg[2]) begin
      rd_value[7:0] = d_rd;
    end else if (sel_reg[3]) begin
      rd_value[7:0] = b_dir;
    end else if (sel_reg[4]) begin
      rd_value[5:0]          = c_dir;
      rd_value[`MPG_CLKEN_BIT] = clken_q;
    end else if (sel_reg[5]) begin
      rd_value[7:0] = d_dir;
    end else if (sel_reg[6]) begin
      rd_value[7:0] = e_rd;
    end else if (sel_reg[7]) begin
      rd_value[7:0] = e_dir;
    end
  end

  // ==========================================================
  // bus slave
  // registered read data costs a wait state but keeps pins off the bus path
  mpg_apb u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr),
    .hit      (hit),
    .rd_value (rd_value),
    .wr_stb   (wr_stb)
  );

endmodule // mpg_top

`default_nettype wire

// File: hdl/mpg_defs.vh
// Purpose: constants for the four-port general-purpose I/O block
// Assumes: included by bare name; definitions only
// Notes:   register index times four gives the APB byte address
`ifndef MPG_DEFS_VH
`define MPG_DEFS_VH

// ==========================================================
// register indices
`define MPG_IDX_B_LATCH  6'h01
`define MPG_IDX_C_LATCH  6'h02
`define MPG_IDX_D_LATCH  6'h03
`define MPG_IDX_B_DIR    6'h05
`define MPG_IDX_C_DIR    6'h06
`define MPG_IDX_D_DIR    6'h07
`define MPG_IDX_E_LATCH  6'h08
`define MPG_IDX_E_DIR    6'h0C

// ==========================================================
// fields and reset values
`define MPG_DIR_RESET    8'h00
`define MPG_CLKEN_BIT    7
`define MPG_CLKOUT_PIN   2
`define MPG_TIMER_ONE_EXTERNAL_CLOCK_PIN    6
`define MPG_TIMER_TWO_EXTERNAL_CLOCK_PIN    4
`define MPG_PS_EXT       3'h7
`define MPG_ADC_D_BASE   5'h08
`define MPG_ADC_B_BASE   5'h00

`endif

// File: hdl/mpg_apb.v
// Purpose: APB slave front end with one wait state
// Assumes: pclk single clock; presetn asynchronous active low
// Notes:   read data is captured on the same edge that pready rises
`timescale 1ns/1ps
`default_nettype none

module mpg_apb (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // register file side
  input  wire        hit,
  input  wire [31:0] rd_value,
  output wire        wr_stb
);

  // ==========================================================
  // access phase tracking
  wire acc_first = psel & penable & ~pready;

  // writes land only at the completing edge
  assign wr_stb = psel & penable & pready & pwrite & ~pslverr;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~hit;
      if (acc_first) begin
        prdata <= (pwrite | ~hit) ? 32'h0000_0000 : rd_value;
      end
    end
  end

endmodule // mpg_apb

`default_nettype wire

// File: hdl/mpg_port.v
// Purpose: one generic port: latch, direction, readback, pin drive
// Assumes: pin inputs synchronous to pclk
// Notes:   latch has no reset on purpose
`timescale 1ns/1ps
`default_nettype none

module mpg_port #(
  parameter W = 8
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // register writes
  input  wire         wr_latch,
  input  wire         wr_dir,
  input  wire [W-1:0] wdata,
  // sharing controls
  input  wire [W-1:0] own,
  input  wire [W-1:0] own_out,
  input  wire [W-1:0] own_oe,
  input  wire [W-1:0] zero_if_in,
  input  wire [W-1:0] rd_zero,
  // pins
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_out_q,
  output reg  [W-1:0] pin_oe_q,
  // register view
  output reg  [W-1:0] latch_q,
  output reg  [W-1:0] dir_q,
  output wire [W-1:0] rdata
);

  // ==========================================================
  // latch survives reset
  always @(posedge pclk) begin
    if (wr_latch) begin
      latch_q <= wdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= {W{1'b0}};
    end else if (wr_dir) begin
      dir_q <= wdata;
    end
  end

  // ==========================================================
  // latch or pin readback
  assign rdata = ~rd_zero & ((dir_q & latch_q) | (~dir_q & ~zero_if_in & pin_in));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= {W{1'b0}};
      pin_oe_q  <= {W{1'b0}};
    end else begin
      pin_out_q <= (own & own_out) | (~own & latch_q);
      pin_oe_q  <= (own & own_oe) | (~own & dir_q);
    end
  end

endmodule // mpg_port

`default_nettype wire

// File: test/mpg_sva.sv
// Purpose: port-level checks for mpg_top
// Assumes: bound to mpg_top; writes land on the pready edge
// Notes:   clock enable is mirrored here since it is not a port
`timescale 1ns/1ps
`default_nettype none
`include "mpg_defs.vh"

module mpg_sva (
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // peripheral selects
  input wire logic [4:0]  analog_channel_select,
  input wire logic [2:0]  timer_one_prescaler_select,
  input wire logic [2:0]  timer_two_prescaler_select,
  input wire logic [7:0]  fifth_port_periph_en,
  input wire logic [7:0]  fifth_port_periph_out,
  input wire logic [7:0]  fifth_port_periph_oe,
  // pins
  input wire logic [7:0]  port_b_pin_oe,
  input wire logic [5:0]  port_c_pin_out,
  input wire logic [5:0]  port_c_pin_oe,
  input wire logic [7:0]  port_d_pin_oe,
  input wire logic [7:0]  port_e_pin_out,
  input wire logic [7:0]  port_e_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ======
  // helpers
  logic clk_en_q;
  wire  wr   = psel && penable && pready && pwrite;
  wire  rd_c = psel && pready && !pwrite && paddr == {`MPG_IDX_C_LATCH, 2'b00};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      clk_en_q <= 1'b0;
    else if (wr && paddr == {`MPG_IDX_C_DIR, 2'b00})
      clk_en_q <= pwdata[`MPG_CLKEN_BIT];
  end

  // ======
  // sequences
  sequence s_bdir_wr;
    wr && paddr == {`MPG_IDX_B_DIR, 2'b00} && analog_channel_select[4:3] != 2'b00;
  endsequence
  // two cycles on, so the toggle flop already runs
  sequence s_clk_on;
    $past(clk_en_q) && $past(clk_en_q, 2);
  endsequence

  // ======
  // properties
  // drive follows direction
  property p_dir_b;
    s_bdir_wr |=> ##1 port_b_pin_oe == $past(pwdata[7:0], 2);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("second port enable wrong");
  property p_reset;
    !$past(presetn) |-> {port_b_pin_oe, port_c_pin_oe, port_d_pin_oe, port_e_pin_oe} == 30'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("pin driven after reset");
  property p_clk;
    s_clk_on |-> port_c_pin_oe[2] && port_c_pin_out[2] != $past(port_c_pin_out[2]);
  endproperty
  a_clk: assert property (p_clk) else $error("clock output not running");
  property p_rd_c;
    clk_en_q && rd_c |-> !prdata[2];
  endproperty
  a_rd_c: assert property (p_rd_c) else $error("clock pin read not zero");
  property p_c_width;
    rd_c |-> prdata[31:6] == 26'h0;
  endproperty
  a_c_width: assert property (p_c_width) else $error("third port too wide");
  property p_ta;
    $past(timer_one_prescaler_select) == `MPG_PS_EXT |-> !port_d_pin_oe[6];
  endproperty
  a_ta: assert property (p_ta) else $error("timer one pin driven");
  property p_tb;
    $past(timer_two_prescaler_select) == `MPG_PS_EXT |-> !port_d_pin_oe[4];
  endproperty
  a_tb: assert property (p_tb) else $error("timer two pin driven");
  property p_adc_b;
    $past(analog_channel_select) < 5'h08 |->
      !port_b_pin_oe[$past(analog_channel_select[2:0])];
  endproperty
  a_adc_b: assert property (p_adc_b) else $error("adc pin driven");
  property p_adc_d;
    $past(analog_channel_select[4:3]) == 2'b01 && $past(analog_channel_select[2:0]) != 3'h7
      |-> !port_d_pin_oe[$past(analog_channel_select[2:0])];
  endproperty
  a_adc_d: assert property (p_adc_d) else $error("adc pin driven");
  property p_e_own;
    $past(presetn) |->
      ((port_e_pin_oe ^ $past(fifth_port_periph_oe)) & $past(fifth_port_periph_en)) == 8'h00 &&
      ((port_e_pin_out ^ $past(fifth_port_periph_out)) & $past(fifth_port_periph_en)) == 8'h00;
  endproperty
  a_e_own: assert property (p_e_own) else $error("fifth port owned pin wrong");
endmodule // mpg_sva

bind mpg_top mpg_sva mpg_sva_i (.*);
`default_nettype wire

// File: test/mpg_pin_model.sv
// Purpose: far-side level of one port's pins
// Assumes: no pull resistors on the pins
// Notes:   an undriven pin takes the level the bench gives it
`timescale 1ns/1ps
`default_nettype none

module mpg_pin_model #(
  parameter int W = 8
) (
  // from the block
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  // outside level and result
  input  wire logic [W-1:0] ext,
  output wire logic [W-1:0] pin
);
  // ======
  // a driven pin reads back its own drive
  assign pin = (out & oe) | (ext & ~oe);
endmodule // mpg_pin_model
`default_nettype wire

// File: test/mpg_top_tb.sv
// Purpose: self-checking bench for mpg_top
// Assumes: apb slave answers with one wait state
// Notes:   pins come back through mpg_pin_model
`timescale 1ns/1ps
`default_nettype none
`include "mpg_defs.vh"

module mpg_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0]  paddr, pen, pout, poe, ext_b, ext_d, ext_e;
  logic [7:0]  b_in, b_out, b_oe, d_in, d_out, d_oe, e_in, e_out, e_oe;
  logic [5:0]  ext_c, c_in, c_out, c_oe;
  logic [31:0] pwdata, prdata, rdv;
  logic [4:0]  asel;
  logic [2:0]  ta, tb;
  int          num_errors, n_checks, cyc;

  // ======
  // design and pins
  mpg_top mpg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .analog_channel_select(asel), .timer_one_prescaler_select(ta),
    .timer_two_prescaler_select(tb), .fifth_port_periph_en(pen),
    .fifth_port_periph_out(pout), .fifth_port_periph_oe(poe), .port_b_pin_in(b_in),
    .port_b_pin_out(b_out), .port_b_pin_oe(b_oe), .port_c_pin_in(c_in),
    .port_c_pin_out(c_out), .port_c_pin_oe(c_oe), .port_d_pin_in(d_in),
    .port_d_pin_out(d_out), .port_d_pin_oe(d_oe), .port_e_pin_in(e_in),
    .port_e_pin_out(e_out), .port_e_pin_oe(e_oe));
  mpg_pin_model #(.W(8)) pins_b_i (.out(b_out), .oe(b_oe), .ext(ext_b), .pin(b_in));
  mpg_pin_model #(.W(6)) pins_c_i (.out(c_out), .oe(c_oe), .ext(ext_c), .pin(c_in));
  mpg_pin_model #(.W(8)) pins_d_i (.out(d_out), .oe(d_oe), .ext(ext_d), .pin(d_in));
  mpg_pin_model #(.W(8)) pins_e_i (.out(e_out), .oe(e_oe), .ext(ext_e), .pin(e_in));

  // ======
  // common tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // pins follow registers one edge late
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ======
  // scenarios
  task automatic t_reset;
    settle();
    chk(32'({b_oe, c_oe, d_oe, e_oe}), 32'h0);
    apb(0, `MPG_IDX_B_DIR, 8'h00); chk(rdv, 32'h0);
    apb(0, `MPG_IDX_C_DIR, 8'h00); chk(rdv, 32'h0);
    apb(0, `MPG_IDX_D_DIR, 8'h00); chk(rdv, 32'h0);
  endtask

  task automatic t_port_b;
    apb(1, `MPG_IDX_B_LATCH, 8'hA5);
    apb(0, `MPG_IDX_B_LATCH, 8'h00); chk(rdv, 32'hC3);
    apb(1, `MPG_IDX_B_DIR, 8'h0F);
    apb(0, `MPG_IDX_B_LATCH, 8'h00); chk(rdv, 32'hC5);
    settle();
    chk(32'(b_oe), 32'h0F);
    chk(32'(b_out & b_oe), 32'h05);
    asel <= 5'h06;
    apb(0, `MPG_IDX_B_LATCH, 8'h00); chk(rdv, 32'h85);
    asel <= 5'h02;
    settle();
    chk(32'(b_oe), 32'h0B);
    asel <= 5'h1F;
  endtask

  task automatic t_keep;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `MPG_IDX_B_DIR, 8'h00); chk(rdv, 32'h0);
    apb(1, `MPG_IDX_B_DIR, 8'hFF);
    apb(0, `MPG_IDX_B_LATCH, 8'h00); chk(rdv, 32'hA5);
  endtask

  task automatic t_port_c;
    logic v;
    apb(1, `MPG_IDX_C_LATCH, 8'hFF);
    apb(1, `MPG_IDX_C_DIR, 8'h3F);
    apb(0, `MPG_IDX_C_LATCH, 8'h00); chk(rdv, 32'h3F);
    apb(1, `MPG_IDX_C_DIR, 8'h83);
    apb(0, `MPG_IDX_C_DIR, 8'h00); chk(rdv, 32'h83);
    apb(0, `MPG_IDX_C_LATCH, 8'h00); chk(rdv, 32'h2B);
    settle();
    chk(32'(c_oe), 32'h07);
    v = c_out[2];
    @(posedge pclk);
    #1;
    chk(32'(c_out[2]), {31'h0, ~v});
    apb(1, `MPG_IDX_C_DIR, 8'h00);
    settle();
    chk(32'(c_oe), 32'h0);
  endtask

  task automatic t_port_d;
    apb(1, `MPG_IDX_D_LATCH, 8'hF0);
    apb(1, `MPG_IDX_D_DIR, 8'hFF);
    ta <= `MPG_PS_EXT;
    tb <= `MPG_PS_EXT;
    settle();
    chk(32'(d_oe), 32'hAF);
    chk(32'(d_out & d_oe), 32'hA0);
    apb(1, `MPG_IDX_D_DIR, 8'h0F);
    apb(0, `MPG_IDX_D_LATCH, 8'h00); chk(rdv, 32'hA0);
    ta <= 3'h0;
    tb <= 3'h0;
    apb(0, `MPG_IDX_D_LATCH, 8'h00); chk(rdv, 32'hF0);
    asel <= 5'h0D;
    apb(0, `MPG_IDX_D_LATCH, 8'h00); chk(rdv, 32'hD0);
    asel <= 5'h09;
    settle();
    chk(32'(d_oe), 32'h0D);
    asel <= 5'h1F;
  endtask

  task automatic t_port_e;
    apb(1, `MPG_IDX_E_LATCH, 8'h5A);
    apb(1, `MPG_IDX_E_DIR, 8'h0F);
    pen  <= 8'hF0;
    pout <= 8'h90;
    poe  <= 8'hC0;
    settle();
    chk(32'(e_oe), 32'hCF);
    chk(32'(e_out & e_oe), 32'h8A);
    apb(0, `MPG_IDX_E_LATCH, 8'h00); chk(rdv, 32'hBA);
    apb(0, 6'h3F, 8'h00); chk({errv, rdv[30:0]}, 32'h8000_0000);
  endtask

  // ======
  // clock, timeout, main
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    asel    = 5'h1F;
    ta      = 3'h0;
    tb      = 3'h0;
    pen     = 8'h00;
    pout    = 8'h00;
    poe     = 8'h00;
    ext_b   = 8'hC3;
    ext_c   = 6'h2A;
    ext_d   = 8'hFF;
    ext_e   = 8'h3C;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_port_b();
    t_keep();
    t_port_c();
    t_port_d();
    t_port_e();
    conclude();
  end
endmodule // mpg_top_tb
`default_nettype wire
